// *** hdl/bmcrp_pkg.sv ***
package bmcrp_pkg;

  // register block offsets (byte addresses inside the slave window)
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_KERNEL_PROG_BASE = 8'h10;
  localparam logic [7:0] ADDR_USER_DATA_BASE = 8'h20;
  localparam logic [7:0] ADDR_RAM_SIZE = 8'h40;

  // alias sub-offsets: plain write, clear, set, invert
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLEAR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_INVERT = 2'h3;

  // configuration and base register field positions
  localparam int POS_DMA_FLASH_CACHEABLE = 26;
  localparam int POS_SHARED_BUS_ERROR_ENABLE = 20;
  localparam int POS_DEBUG_UNIT_ERROR_ENABLE = 19;
  localparam int POS_DMA_ERROR_ENABLE = 18;
  localparam int POS_CPU_DATA_ERROR_ENABLE = 17;
  localparam int POS_CPU_FETCH_ERROR_ENABLE = 16;
  localparam int POS_RAM_WAIT_STATE_SELECT = 6;
  localparam int POS_ARBITRATION_MODE_LSB = 0;
  localparam int POS_BASE_LSB = 10;

  // initiator indices into the error enable vector
  localparam int NUM_INITIATORS = 5;
  localparam int INIT_CPU_FETCH = 0;
  localparam int INIT_CPU_DATA = 1;
  localparam int INIT_DMA = 2;
  localparam int INIT_DEBUG_UNIT = 3;
  localparam int INIT_SHARED_BUS = 4;

  // writable masks and reset values
  localparam logic [31:0] CONFIG_WRITE_MASK = 32'h041F0047;
  localparam logic [31:0] CONFIG_RESET = 32'h041F0041;
  localparam logic [31:0] BASE_WRITE_MASK = 32'h0000FC00;
  localparam logic [31:0] BASE_RESET = 32'h00000000;

  // data RAM size answers
  localparam logic [31:0] RAM_SIZE_32K = 32'h00008000;
  localparam logic [31:0] RAM_SIZE_64K = 32'h00010000;

  // arbitration modes
  localparam logic [2:0] ARB_MODE_0 = 3'h0;
  localparam logic [2:0] ARB_MODE_1 = 3'h1;
  localparam logic [2:0] ARB_MODE_2 = 3'h2;

  // configuration bundle handed to the matrix fabric
  typedef struct packed {
    logic dmaFlashCacheable;
    logic [NUM_INITIATORS-1:0] errorEnable;
    logic ramWaitStateSelect;
    logic [2:0] arbitrationModeSelect;
    logic [15:0] ramKernelProgramBase;
    logic [15:0] ramUserDataBase;
  } bmcrp_cfg_t;

  // dma flash cache request and answer
  typedef struct packed {
    logic hit;
    logic miss;
  } bmcrp_dma_req_t;

  typedef struct packed {
    logic serveFromCache;
    logic allocateLine;
  } bmcrp_dma_ans_t;

endpackage : bmcrp_pkg

// *** hdl/bmcrp_err_gate.sv ***
module bmcrp_err_gate
  import bmcrp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [NUM_INITIATORS-1:0] errorEnable,
  input wire logic cpuDebugMode,
  input wire logic [NUM_INITIATORS-1:0] unmappedAccess,
  output logic [NUM_INITIATORS-1:0] busErrorException
);

  typedef struct packed {
    logic [NUM_INITIATORS-1:0] busError;
  } bmcrp_gate_state_t;

  bmcrp_gate_state_t s_reg;
  bmcrp_gate_state_t s_next;
  logic [NUM_INITIATORS-1:0] gated;

  // per initiator: enable gates the exception, cpu paths muted in debug mode
  for (genvar i = 0; i < NUM_INITIATORS; i++) begin : g_init
    if (i == INIT_CPU_FETCH || i == INIT_CPU_DATA) begin : g_cpu
      assign gated[i] = unmappedAccess[i] & errorEnable[i] & ~cpuDebugMode; // RULE6 RULE7
    end else begin : g_other
      assign gated[i] = unmappedAccess[i] & errorEnable[i]; // RULE3 RULE4 RULE5
    end
  end

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.busError = gated;
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign busErrorException = s_reg.busError;

endmodule : bmcrp_err_gate

// *** hdl/bmcrp_top.sv ***
// Summary of operation
// RULE1: bit 26 set makes dma reads of program flash allocate in cache when data caching is on; resets to one.
// RULE2: bit 26 clear still serves dma hits from cache but dma misses never allocate a line.
// RULE3: bit 20 gates bus-error exceptions for unmapped shared bus accesses; resets to one.
// RULE4: bit 19 gates bus-error exceptions for unmapped debug unit accesses; resets to one.
// RULE5: bit 18 gates bus-error exceptions for unmapped dma accesses; resets to one.
// RULE6: bit 17 gates bus-error exceptions for unmapped cpu data accesses, muted in debug mode; resets to one.
// RULE7: bit 16 gates bus-error exceptions for unmapped cpu fetches, muted in debug mode; resets to one.
// RULE8: bit 6 selects one data RAM address setup wait state for cpu accesses when set, none when clear; resets to one.
// RULE9: bits 2 to 0 select arbitration mode 0, 1 (reset) or 2, and codes 3 to 7 are reserved for software.
// RULE10: unimplemented bits of the configuration and base registers read as zero.
// RULE11: bits 15 to 10 of the kernel program base set where kernel program space begins in RAM.
// RULE12: bits 9 to 0 of both base registers are read-only zero, giving 1 KB steps.
// RULE13: reset clears both base registers so all of RAM is kernel data.
// RULE14: software keeps each base register no larger than the reported RAM size.
// RULE15: bits 15 to 10 of the user data base set where user data begins, kept above the kernel base by software.
// RULE16: the RAM size register is read-only and returns the RAM size in bytes.
// RULE17: writes to read-only and unimplemented bits are dropped without side effects.
module bmcrp_top
  import bmcrp_pkg::*;
#(
  parameter bit RAM_IS_64K = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fabric side
  output bmcrp_cfg_t cfg,
  input wire logic cpuDebugMode,
  input wire logic [NUM_INITIATORS-1:0] unmappedAccess,
  output logic [NUM_INITIATORS-1:0] busErrorException,
  input wire logic dataCacheEnable,
  input wire bmcrp_dma_req_t dmaReq,
  output bmcrp_dma_ans_t dmaAns
);

  localparam logic [31:0] RAM_SIZE = RAM_IS_64K ? RAM_SIZE_64K : RAM_SIZE_32K;

  typedef struct packed {
    logic [31:0] config_reg;
    logic [31:0] kernelBase;
    logic [31:0] userBase;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
    bmcrp_dma_ans_t dma;
  } bmcrp_state_t;

  bmcrp_state_t s_reg;
  bmcrp_state_t s_next;

  logic access;
  logic hit;
  logic [31:0] readValue;
  logic [1:0] op;

  // applies a write, clear, set or invert alias under a writable mask
  function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] wdata,
                                           input logic [1:0] kind, input logic [31:0] mask);
    logic [31:0] m;
    m = wdata & mask;
    unique case (kind)
      OP_WRITE: apply_op = (old & ~mask) | m;
      OP_CLEAR: apply_op = old & ~m;
      OP_SET: apply_op = old | m;
      OP_INVERT: apply_op = old ^ m;
    endcase
  endfunction : apply_op

  // address decode and read mux
  always_comb begin
    access = psel & penable;
    op = paddr[3:2];
    hit = 1'b1;
    readValue = 32'h00000000;
    unique case ({paddr[7:4], 4'h0})
      ADDR_CONFIG: readValue = s_reg.config_reg & CONFIG_WRITE_MASK; // RULE10
      ADDR_KERNEL_PROG_BASE: readValue = s_reg.kernelBase & BASE_WRITE_MASK; // RULE10 RULE12
      ADDR_USER_DATA_BASE: readValue = s_reg.userBase & BASE_WRITE_MASK; // RULE10 RULE12
      ADDR_RAM_SIZE: begin
        hit = (op == OP_WRITE);
        readValue = hit ? RAM_SIZE : 32'h00000000; // RULE16
      end
      default: hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
      readValue = 32'h00000000;
    end
  end

  // next state: one wait cycle, write commits at the edge that sees pready high
  always_comb begin
    s_next = s_reg;
    s_next.ready = 1'b0;
    s_next.slvErr = 1'b0;
    if (access && !s_reg.ready) begin
      s_next.ready = 1'b1;
      s_next.slvErr = ~hit;
      s_next.rdata = pwrite ? 32'h00000000 : readValue;
    end
    if (access && s_reg.ready && pwrite && hit) begin
      unique case ({paddr[7:4], 4'h0})
        ADDR_CONFIG: begin
          // reserved arbitration codes are stored as written
          s_next.config_reg = apply_op(s_reg.config_reg, pwdata, op, CONFIG_WRITE_MASK); // RULE9 RULE17
        end
        ADDR_KERNEL_PROG_BASE: begin
          s_next.kernelBase = apply_op(s_reg.kernelBase, pwdata, op, BASE_WRITE_MASK); // RULE11 RULE17
        end
        ADDR_USER_DATA_BASE: begin
          s_next.userBase = apply_op(s_reg.userBase, pwdata, op, BASE_WRITE_MASK); // RULE15 RULE17
        end
        default: begin
          s_next.rdata = s_reg.rdata; // size register ignores writes
        end
      endcase
    end
    // dma flash cache policy
    s_next.dma.serveFromCache = dmaReq.hit; // RULE2
    s_next.dma.allocateLine = dmaReq.miss & dataCacheEnable
                              & s_reg.config_reg[POS_DMA_FLASH_CACHEABLE]; // RULE1 RULE2
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg.config_reg <= CONFIG_RESET; // RULE1 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9
      s_reg.kernelBase <= BASE_RESET; // RULE13
      s_reg.userBase <= BASE_RESET; // RULE13
      s_reg.rdata <= 32'h00000000;
      s_reg.ready <= 1'b0;
      s_reg.slvErr <= 1'b0;
      s_reg.dma <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // bus error gating per initiator
  bmcrp_err_gate u_err_gate (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .errorEnable(s_reg.config_reg[POS_SHARED_BUS_ERROR_ENABLE:POS_CPU_FETCH_ERROR_ENABLE]),
    .cpuDebugMode(cpuDebugMode),
    .unmappedAccess(unmappedAccess),
    .busErrorException(busErrorException)
  );

  // outputs, all bits of the state register
  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.slvErr;
  assign dmaAns = s_reg.dma;
  assign cfg.dmaFlashCacheable = s_reg.config_reg[POS_DMA_FLASH_CACHEABLE]; // RULE1
  assign cfg.errorEnable = s_reg.config_reg[POS_SHARED_BUS_ERROR_ENABLE:POS_CPU_FETCH_ERROR_ENABLE];
  assign cfg.ramWaitStateSelect = s_reg.config_reg[POS_RAM_WAIT_STATE_SELECT]; // RULE8
  assign cfg.arbitrationModeSelect = s_reg.config_reg[POS_ARBITRATION_MODE_LSB +: 3]; // RULE9
  assign cfg.ramKernelProgramBase = s_reg.kernelBase[15:0] & BASE_WRITE_MASK[15:0]; // RULE11
  assign cfg.ramUserDataBase = s_reg.userBase[15:0] & BASE_WRITE_MASK[15:0]; // RULE15

endmodule : bmcrp_top

// *** verif/bmcrp_props.sv ***
module bmcrp_props
  import bmcrp_pkg::*;
#(
  parameter bit RAM_IS_64K = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire bmcrp_cfg_t cfg,
  input wire logic cpuDebugMode,
  input wire logic [NUM_INITIATORS-1:0] unmappedAccess,
  input wire logic [NUM_INITIATORS-1:0] busErrorException,
  input wire logic dataCacheEnable,
  input wire bmcrp_dma_req_t dmaReq,
  input wire bmcrp_dma_ans_t dmaAns
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic rdOk;
  // error-free read answer, address still held by the master
  assign rdOk = pready && !pwrite && !pslverr;
  AST_ALLOC_GATE: assert property (1'b1 |=> dmaAns.allocateLine ==
    $past(dmaReq.miss && dataCacheEnable && cfg.dmaFlashCacheable)) else $error("allocate wrong");
  AST_HIT_SERVED: assert property (1'b1 |=> dmaAns.serveFromCache == $past(dmaReq.hit))
    else $error("hit not served");
  AST_ERR_OTHERS: assert property (1'b1 |=> busErrorException[4:2] ==
    $past(unmappedAccess[4:2] & cfg.errorEnable[4:2])) else $error("error gate wrong");
  AST_ERR_CPU: assert property (1'b1 |=> busErrorException[1:0] ==
    $past(unmappedAccess[1:0] & cfg.errorEnable[1:0] & {2{!cpuDebugMode}}))
    else $error("cpu error gate wrong");
  AST_CFG_HOLD: assert property (!(psel && penable && pready && pwrite) |=> $stable(cfg))
    else $error("config moved without write");
  AST_CFG_ZEROS: assert property (rdOk && paddr[7:4] == 4'h0 |-> (prdata & ~CONFIG_WRITE_MASK) == 0)
    else $error("config spare bits set");
  AST_BASE_ZEROS: assert property (rdOk && paddr[7:4] inside {4'h1, 4'h2} |->
    (prdata & ~BASE_WRITE_MASK) == 0) else $error("base low bits set");
  AST_SIZE: assert property (rdOk && paddr == ADDR_RAM_SIZE |->
    prdata == (RAM_IS_64K ? RAM_SIZE_64K : RAM_SIZE_32K)) else $error("size wrong");
  AST_KBASE_OUT: assert property (rdOk && paddr == ADDR_KERNEL_PROG_BASE |->
    prdata[15:0] == cfg.ramKernelProgramBase) else $error("kernel base mismatch");
  // main scenarios reached
  COV_WRITE: cover property (psel && penable && pready && pwrite);
  COV_DEBUG_MUTE: cover property (cpuDebugMode && unmappedAccess[0] && cfg.errorEnable[0]);
  COV_ALLOC: cover property (dmaAns.allocateLine);
endmodule : bmcrp_props

bind bmcrp_top bmcrp_props #(.RAM_IS_64K(RAM_IS_64K)) bmcrp_props_inst (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cfg(cfg), .cpuDebugMode(cpuDebugMode),
  .unmappedAccess(unmappedAccess), .busErrorException(busErrorException),
  .dataCacheEnable(dataCacheEnable), .dmaReq(dmaReq), .dmaAns(dmaAns));

// *** verif/bmcrp_initiators.sv ***
module bmcrp_initiators
  import bmcrp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  output logic cpuDebugMode,
  output logic [NUM_INITIATORS-1:0] unmappedAccess,
  output logic dataCacheEnable,
  output bmcrp_dma_req_t dmaReq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] stepReg;
  // walks every mix of unmapped accesses, debug mode and dma lookups
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stepReg <= 9'h000;
    end else begin
      stepReg <= stepReg + 9'h001;
    end
  end
  // each initiator raises its own events independently
  assign unmappedAccess = stepReg[4:0];
  assign cpuDebugMode = stepReg[5];
  assign dmaReq = stepReg[7:6];
  assign dataCacheEnable = stepReg[8];
endmodule : bmcrp_initiators

// *** verif/testbench.sv ***
module testbench
  import bmcrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, cpuDebugMode, dataCacheEnable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NUM_INITIATORS-1:0] unmappedAccess;
  bmcrp_dma_req_t dmaReq;
  bmcrp_cfg_t cfg;
  int errors, tests_run;
  bmcrp_top bmcrp_top_inst (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg), .cpuDebugMode(cpuDebugMode),
    .unmappedAccess(unmappedAccess), .busErrorException(),
    .dataCacheEnable(dataCacheEnable), .dmaReq(dmaReq), .dmaAns());
  bmcrp_initiators bmcrp_initiators_inst (.clk(clk), .rst(rst), .cpuDebugMode(cpuDebugMode),
    .unmappedAccess(unmappedAccess), .dataCacheEnable(dataCacheEnable), .dmaReq(dmaReq));
  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer: setup, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // pready, prdata and pslverr are read at the rising edge, before that edge's updates land
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h00000000, r, e);
    chk(r, exp);
  endtask : rd
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CONFIG, CONFIG_RESET);
    rd(ADDR_KERNEL_PROG_BASE, BASE_RESET);
    rd(ADDR_USER_DATA_BASE, BASE_RESET);
    rd(ADDR_RAM_SIZE, RAM_SIZE_32K);
    repeat (520) @(posedge clk);
    wr(ADDR_CONFIG, 32'hFFFFFFFF);
    rd(ADDR_CONFIG, 32'h041F0047);
    wr(ADDR_CONFIG, 32'h00000000);
    rd(ADDR_CONFIG, 32'h00000000);
    repeat (520) @(posedge clk);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CONFIG, 32'(m));
      rd(ADDR_CONFIG, 32'(m));
    end
    wr(ADDR_CONFIG + 8'h08, 32'h00000040);
    @(posedge clk);
    chk(32'(cfg.ramWaitStateSelect), 32'h00000001);
    wr(ADDR_CONFIG + 8'h04, 32'h00000040);
    rd(ADDR_CONFIG, 32'h00000002);
    wr(ADDR_CONFIG + 8'h0C, 32'h04000000);
    rd(ADDR_CONFIG, 32'h04000002);
    wr(ADDR_KERNEL_PROG_BASE, 32'hFFFF17FF);
    rd(ADDR_KERNEL_PROG_BASE, 32'h00001400);
    wr(ADDR_USER_DATA_BASE, 32'hFFFF63FF);
    rd(ADDR_USER_DATA_BASE, 32'h00006000);
    wr(ADDR_RAM_SIZE, 32'h00000000);
    rd(ADDR_RAM_SIZE, RAM_SIZE_32K);
    xfer(1'b0, 8'h44, 32'h00000000, r, e);
    chk(32'(e), 32'h00000001);
    repeat (520) @(posedge clk);
    tally_and_finish();
  end
endmodule : testbench
